// ### ftbp_chan_mon.sv
// receive monitor of one fiber channel: light loss and fault pattern
`timescale 1ns/1ns
module ftbp_chan_mon
  import ftbp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  ftbp_mon_if.mon  bus
);

  // ==========================================================================
  // fault pattern recogniser
  logic [PAT_LEN-1:0]   shift_ff;
  logic [PAT_LEN-1:0]   nxt_shift;
  logic [PAT_AGE_W-1:0] age_ff;
  logic [PAT_AGE_W-1:0] nxt_age;
  logic                 pat_present;
  logic [1:0]           raw_lvl;

  assign pat_present = (age_ff < PAT_AGE_IDLE);
  assign raw_lvl     = {pat_present, bus.light_det};

  // the pattern repeats every PAT_LEN bits, so a match ages out after that
  always_comb begin
    nxt_shift = {shift_ff[PAT_LEN-2:0], bus.rx_data};
    nxt_age   = age_ff;
    if (shift_ff == FAULT_PATTERN) begin
      nxt_age = '0;
    end else if (pat_present) begin
      nxt_age = age_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_ff <= '0;
      age_ff   <= PAT_AGE_IDLE;
    end else begin
      shift_ff <= nxt_shift;
      age_ff   <= nxt_age;
    end
  end

  // ==========================================================================
  // debounce of light level and pattern presence
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYC - 1);

  for (genvar i = 0; i < 2; i++) begin : deb
    logic             filt_ff;
    logic             nxt_filt;
    logic [DEB_W-1:0] cnt_ff;
    logic [DEB_W-1:0] nxt_cnt;

    always_comb begin
      nxt_filt = filt_ff;
      nxt_cnt  = '0;
      if (raw_lvl[i] != filt_ff) begin
        if (cnt_ff == DEB_LAST) begin
          nxt_filt = raw_lvl[i];
        end else begin
          nxt_cnt = cnt_ff + 10'h001;
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        filt_ff <= MON_FILT_RST[i];
        cnt_ff  <= '0;
      end else begin
        filt_ff <= nxt_filt;
        cnt_ff  <= nxt_cnt;
      end
    end
  end

  // light level comes from the optical detector, not from ring data,
  // so loss is seen even with no stations inserted
  assign bus.light_lost   = ~deb[MON_LIGHT].filt_ff;
  assign bus.remote_fault = deb[MON_PAT].filt_ff;

endmodule

// ### ftbp_mon_if.sv
// per-channel link between the receive monitor and the trunk controller
`timescale 1ns/1ns
interface ftbp_mon_if;
  logic light_det;
  logic rx_data;
  logic light_lost;
  logic remote_fault;

  modport mon (
    input  light_det,
    input  rx_data,
    output light_lost,
    output remote_fault
  );

  modport ctl (
    output light_det,
    output rx_data,
    input  light_lost,
    input  remote_fault
  );
endinterface

// ### ftbp_peer.sv
// model of the peer trunk unit at the far end of both fibers
`timescale 1ns/1ns
module ftbp_peer
  import ftbp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              prot_en,
  input  wire logic [NUM_CH-1:0] cut,
  input  wire logic [NUM_CH-1:0] our_light,
  input  wire logic              data_in,
  output logic      [NUM_CH-1:0] light_det,
  output logic      [NUM_CH-1:0] rx_data
);
  logic [PAT_IDX_W-1:0] idx_ff;

  // ==========================================================================
  // a dark fiber toggles so a stale level never passes for data
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idx_ff    <= PAT_IDX_FIRST;
      light_det <= 2'h3;
      rx_data   <= 2'h0;
    end else begin
      idx_ff <= idx_ff - 3'h1;
      for (int c = 0; c < NUM_CH; c++) begin
        light_det[c] <= !cut[c];
        if (cut[c]) begin
          rx_data[c] <= ~rx_data[c];
        end else if (prot_en && !our_light[c]) begin
          rx_data[c] <= FAULT_PATTERN[idx_ff];
        end else begin
          rx_data[c] <= data_in;
        end
      end
    end
  end
endmodule

// ### ftbp_pkg.sv
// constants, register map and state codes of the fiber trunk break protection
package ftbp_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_NS   = 10000;
  localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int DEB_W         = 10;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BLINK_W       = 25;

  // ==========================================================================
  // channels and fault pattern
  localparam int NUM_CH    = 2;
  localparam int PAT_LEN   = 8;
  localparam int PAT_IDX_W = 3;
  localparam int PAT_AGE_W = 4;
  localparam logic [PAT_LEN-1:0]   FAULT_PATTERN = 8'hF0;
  localparam logic [PAT_IDX_W-1:0] PAT_IDX_FIRST = 3'h7;
  localparam logic [PAT_AGE_W-1:0] PAT_AGE_IDLE  = 4'h8;
  localparam int MON_LIGHT = 0;
  localparam int MON_PAT   = 1;
  localparam logic [1:0] MON_FILT_RST = 2'h0;

  // ==========================================================================
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  localparam int CFG_PROT_EN   = 0;
  localparam int CFG_JITTER_EN = 1;
  localparam int CFG_ROLE_EXIT = 2;
  localparam int CFG_REDUNDANT = 3;
  localparam int CFG_RATE_16M  = 4;
  localparam int CFG_W         = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h13;

  localparam int STS_W = 11;

  // ==========================================================================
  // control states
  typedef enum logic [4:0] {
    ST_NORMAL       = 5'h01,
    ST_LOCAL_LOSS   = 5'h02,
    ST_REMOTE_FAULT = 5'h04,
    ST_PROT_OFF     = 5'h08,
    ST_CFG_ERR      = 5'h10
  } ftbp_state_e;

endpackage

// ### ftbp_top.sv
// fiber trunk break protection controller with ring data path
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module ftbp_top
  import ftbp_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [NUM_CH-1:0] fiber_light_det,
  input  wire logic [NUM_CH-1:0] fiber_rx_data,
  output logic      [NUM_CH-1:0] fiber_tx_data,
  input  wire logic              ring_tx_in,
  output logic                   ring_rx_out,
  output logic                   relay_energize,
  output logic                   loopback_active,
  output logic                   active_channel,
  output logic                   fault_indicator,
  output logic                   ring_entry_role,
  output logic                   ring_exit_role,
  output logic                   rate_16m_ind
);

  // ==========================================================================
  // channel monitors
  logic [NUM_CH-1:0] lost;
  logic [NUM_CH-1:0] rfault;

  for (genvar g = 0; g < NUM_CH; g++) begin : ch
    ftbp_mon_if mon_bus ();

    assign mon_bus.light_det = fiber_light_det[g];
    assign mon_bus.rx_data   = fiber_rx_data[g];
    assign lost[g]           = mon_bus.light_lost;
    assign rfault[g]         = mon_bus.remote_fault;

    ftbp_chan_mon u_mon (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .bus     (mon_bus.mon)
    );
  end

  // ==========================================================================
  // register port
  logic [CFG_W-1:0]  cfg_ff;
  logic [CFG_W-1:0]  nxt_cfg;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [STS_W-1:0]  status;
  ftbp_state_e       state_ff;
  ftbp_state_e       nxt_state;
  logic              act_ch_ff;
  logic              nxt_act_ch;
  logic              loop_ff;
  logic              nxt_loop;

  logic prot_en;
  logic jitter_en;
  logic role_exit;
  logic redundant;
  logic cfg_bad;

  assign prot_en   = cfg_ff[CFG_PROT_EN];
  assign jitter_en = cfg_ff[CFG_JITTER_EN];
  assign role_exit = cfg_ff[CFG_ROLE_EXIT];
  assign redundant = cfg_ff[CFG_REDUNDANT];
  // a spare channel with protection off would never be taken into use
  assign cfg_bad   = redundant & ~prot_en;

  assign status = {loop_ff, act_ch_ff, rfault, lost, state_ff};

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_rdata = '0;
    if (reg_wr && (reg_addr == REG_CONFIG)) begin
      nxt_cfg = reg_wdata[CFG_W-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CONFIG: nxt_rdata = {{(DATA_W-CFG_W){1'b0}}, cfg_ff};
        REG_STATUS: nxt_rdata = {{(DATA_W-STS_W){1'b0}}, status};
        default:    nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_ff   <= CFG_RST;
      rdata_ff <= '0;
    end else begin
      cfg_ff   <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // indicator flash divider
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF - 1);

  logic [BLINK_W-1:0] blink_cnt_ff;
  logic [BLINK_W-1:0] nxt_blink_cnt;
  logic               blink_ff;
  logic               nxt_blink;

  always_comb begin
    nxt_blink_cnt = blink_cnt_ff + 25'h0000001;
    nxt_blink     = blink_ff;
    if (blink_cnt_ff == BLINK_LAST) begin
      nxt_blink_cnt = '0;
      nxt_blink     = ~blink_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff     <= nxt_blink;
    end
  end

  // ==========================================================================
  // protection state and indicators
  logic [NUM_CH-1:0] chan_bad;
  logic              sel_lost;
  logic              sel_rfault;
  logic              nxt_relay;
  logic              nxt_fault_led;
  logic              nxt_entry_led;
  logic              nxt_exit_led;
  logic              relay_ff;
  logic              fault_led_ff;
  logic              entry_led_ff;
  logic              exit_led_ff;

  assign chan_bad = lost | rfault;

  always_comb begin
    nxt_act_ch = redundant ? act_ch_ff : 1'b0;
    // the far end sees the fault pattern on the same channel and moves
    // over too, so both ends land on the spare without a ring loop
    if (redundant && chan_bad[act_ch_ff] && !chan_bad[~act_ch_ff]) begin
      nxt_act_ch = ~act_ch_ff;
    end
    sel_lost   = lost[nxt_act_ch];
    sel_rfault = rfault[nxt_act_ch];

    if (cfg_bad) begin
      nxt_state = ST_CFG_ERR;
    end else if (!prot_en) begin
      nxt_state = ST_PROT_OFF;
    end else if (sel_lost) begin
      nxt_state = ST_LOCAL_LOSS;
    end else if (sel_rfault) begin
      nxt_state = ST_REMOTE_FAULT;
    end else begin
      nxt_state = ST_NORMAL;
    end

    nxt_loop      = 1'b0;
    nxt_relay     = 1'b1;
    nxt_fault_led = 1'b0;
    nxt_entry_led = ~role_exit;
    nxt_exit_led  = role_exit;
    unique case (nxt_state)
      ST_NORMAL: begin
        nxt_fault_led = 1'b0;
      end
      ST_LOCAL_LOSS: begin
        nxt_loop      = 1'b1;
        nxt_fault_led = 1'b1;
      end
      ST_REMOTE_FAULT: begin
        nxt_loop      = 1'b1;
        nxt_fault_led = nxt_blink;
      end
      ST_PROT_OFF: begin
        nxt_fault_led = sel_lost;
      end
      ST_CFG_ERR: begin
        // relay dropped: the passive loop keeps the ring closed meanwhile
        nxt_relay     = 1'b0;
        nxt_fault_led = nxt_blink;
        nxt_entry_led = nxt_blink;
        nxt_exit_led  = nxt_blink;
      end
    endcase
  end

  // reset leaves the relay dropped, the same passive loop as power off
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff     <= ST_NORMAL;
      act_ch_ff    <= 1'b0;
      loop_ff      <= 1'b0;
      relay_ff     <= 1'b0;
      fault_led_ff <= 1'b0;
      entry_led_ff <= 1'b0;
      exit_led_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      act_ch_ff    <= nxt_act_ch;
      loop_ff      <= nxt_loop;
      relay_ff     <= nxt_relay;
      fault_led_ff <= nxt_fault_led;
      entry_led_ff <= nxt_entry_led;
      exit_led_ff  <= nxt_exit_led;
    end
  end

  assign relay_energize  = relay_ff;
  assign loopback_active = loop_ff;
  assign active_channel  = act_ch_ff;
  assign fault_indicator = fault_led_ff;
  assign ring_entry_role = entry_led_ff;
  assign ring_exit_role  = exit_led_ff;
  assign rate_16m_ind    = cfg_ff[CFG_RATE_16M];

  // ==========================================================================
  // repeater, fault pattern and loop data path
  logic [2:0]           hist_ff;
  logic [2:0]           nxt_hist;
  logic [PAT_IDX_W-1:0] pat_idx_ff;
  logic [PAT_IDX_W-1:0] nxt_pat_idx;
  logic [NUM_CH-1:0]    tx_ff;
  logic [NUM_CH-1:0]    nxt_tx;
  logic                 rx_out_ff;
  logic                 nxt_rx_out;
  logic                 regen;
  logic                 vote;
  logic [NUM_CH-1:0]    send_pat;

  // a pattern goes out on every channel that lost light, so the far end
  // loops or changes channel; never with protection off
  assign send_pat = (prot_en && !cfg_bad) ? lost : '0;

  // majority of three samples trades one cycle of delay for jitter
  assign vote = (hist_ff[0] & hist_ff[1]) | (hist_ff[1] & hist_ff[2]) |
                (hist_ff[0] & hist_ff[2]);

  always_comb begin
    nxt_hist    = {hist_ff[1:0], ring_tx_in};
    // the same retiming stage serves the main path when exiting the ring
    // and the backup path when entering it
    regen       = jitter_en ? vote : hist_ff[0];
    nxt_pat_idx = pat_idx_ff - 3'h1;
    for (int c = 0; c < NUM_CH; c++) begin
      nxt_tx[c] = send_pat[c] ? FAULT_PATTERN[pat_idx_ff] : regen;
    end
    // both directions run at once over the fiber pair
    if (loop_ff) begin
      nxt_rx_out = regen;
    end else begin
      nxt_rx_out = fiber_rx_data[act_ch_ff];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hist_ff    <= '0;
      pat_idx_ff <= PAT_IDX_FIRST;
      tx_ff      <= '0;
      rx_out_ff  <= 1'b0;
    end else begin
      hist_ff    <= nxt_hist;
      pat_idx_ff <= nxt_pat_idx;
      tx_ff      <= nxt_tx;
      rx_out_ff  <= nxt_rx_out;
    end
  end

  assign fiber_tx_data = tx_ff;
  assign ring_rx_out   = rx_out_ff;

endmodule

// ### ftbp_top_asserts.sv
// port-level checker of the fiber trunk break protection top
`timescale 1ns/1ns
module ftbp_top_asserts
  import ftbp_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_CH-1:0] fiber_light_det,
  input wire logic [NUM_CH-1:0] fiber_rx_data,
  input wire logic [NUM_CH-1:0] fiber_tx_data,
  input wire logic              ring_tx_in,
  input wire logic              ring_rx_out,
  input wire logic              relay_energize,
  input wire logic              loopback_active,
  input wire logic              active_channel,
  input wire logic              fault_indicator,
  input wire logic              ring_entry_role,
  input wire logic              ring_exit_role,
  input wire logic              rate_16m_ind
);
  localparam int DEB = DEBOUNCE_CYC;
  logic [10:0] dark_ff;
  logic [10:0] lit_ff;

  // ==========================================================================
  // saturating run lengths of dark and lit light on channel 0
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dark_ff <= 11'h000;
      lit_ff  <= 11'h000;
    end else begin
      dark_ff <= fiber_light_det[0] ? 11'h000 : dark_ff + {10'h000, ~&dark_ff};
      lit_ff  <= !fiber_light_det[0] ? 11'h000 : lit_ff + {10'h000, ~&lit_ff};
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cfg_write;
    reg_wr && reg_addr == REG_CONFIG;
  endsequence
  sequence s_dark(int n);
    dark_ff >= n && loopback_active && !active_channel;
  endsequence

  property p_reset_quiet;
    $past(sys_rst) |-> !relay_energize && !loopback_active &&
      !fault_indicator && fiber_tx_data == 2'h0;
  endproperty
  property p_loop_powered;
    loopback_active |-> relay_energize;
  endproperty
  property p_role_leds;
    relay_energize |-> ring_entry_role != ring_exit_role;
  endproperty
  property p_cfg_err;
    ring_entry_role && ring_exit_role |->
      fault_indicator && !relay_energize && !loopback_active;
  endproperty
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_cfg_rate;
    s_cfg_write |=> rate_16m_ind == $past(reg_wdata[CFG_RATE_16M]);
  endproperty
  // the fault pattern inverts every four bits
  property p_pattern;
    s_dark(DEB + 10) |-> fiber_tx_data[0] != $past(fiber_tx_data[0], 4);
  endproperty
  property p_steady_led;
    s_dark(DEB + 3) |-> fault_indicator;
  endproperty
  property p_release;
    $fell(loopback_active) && !active_channel |-> lit_ff >= DEB;
  endproperty

  a_reset_quiet:  assert property (p_reset_quiet)
    else $error("reset outputs");
  a_loop_powered: assert property (p_loop_powered)
    else $error("loop unpowered");
  a_role_leds:    assert property (p_role_leds)
    else $error("role leds");
  a_cfg_err:      assert property (p_cfg_err)
    else $error("bad config");
  a_rdata_idle:   assert property (p_rdata_idle)
    else $error("rdata not idle");
  a_cfg_rate:     assert property (p_cfg_rate)
    else $error("rate bit");
  a_pattern:      assert property (p_pattern)
    else $error("no pattern");
  a_steady_led:   assert property (p_steady_led)
    else $error("led not on");
  a_release:      assert property (p_release)
    else $error("early release");
endmodule

bind ftbp_top ftbp_top_asserts #(.BLINK_HALF(BLINK_HALF)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fiber_light_det(fiber_light_det),
  .fiber_rx_data(fiber_rx_data), .fiber_tx_data(fiber_tx_data),
  .ring_tx_in(ring_tx_in), .ring_rx_out(ring_rx_out),
  .relay_energize(relay_energize), .loopback_active(loopback_active),
  .active_channel(active_channel), .fault_indicator(fault_indicator),
  .ring_entry_role(ring_entry_role), .ring_exit_role(ring_exit_role),
  .rate_16m_ind(rate_16m_ind)
);

// ### test_ftbp_top.sv
// self-checking bench of the fiber trunk break protection top
`timescale 1ns/1ns
module test_ftbp_top
  import ftbp_pkg::*;
;
  localparam int BLINK = 8;
  logic              ref_clk, sys_rst, reg_wr, reg_rd, ring_tx_in, ring_rx_out;
  logic              relay_energize, loopback_active, active_channel;
  logic              fault_indicator, ring_entry_role, ring_exit_role;
  logic              rate_16m_ind, traffic, prot_peer, peer_data;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [NUM_CH-1:0] fiber_light_det, fiber_rx_data, fiber_tx_data;
  logic [NUM_CH-1:0] cut, our_light, rx_h;
  logic [3:0]        in_h;
  logic [31:0]       seed;
  int                fail_count, checks_done, t;

  ftbp_top #(.BLINK_HALF(BLINK)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fiber_light_det(fiber_light_det),
    .fiber_rx_data(fiber_rx_data), .fiber_tx_data(fiber_tx_data),
    .ring_tx_in(ring_tx_in), .ring_rx_out(ring_rx_out),
    .relay_energize(relay_energize), .loopback_active(loopback_active),
    .active_channel(active_channel), .fault_indicator(fault_indicator),
    .ring_entry_role(ring_entry_role), .ring_exit_role(ring_exit_role),
    .rate_16m_ind(rate_16m_ind)
  );
  ftbp_peer peer (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .prot_en(prot_peer), .cut(cut),
    .our_light(our_light), .data_in(peer_data),
    .light_det(fiber_light_det), .rx_data(fiber_rx_data)
  );

  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // counts indicator changes over n cycles
  task automatic flashes(input int n, output int cnt);
    logic last;
    cnt = 0;
    @(posedge ref_clk);
    #1 last = fault_indicator;
    repeat (n) begin
      @(posedge ref_clk);
      #1 cnt += (fault_indicator !== last);
      last = fault_indicator;
    end
  endtask
  task automatic path(input logic jit);
    logic e;
    repeat (40) begin
      @(posedge ref_clk);
      #1 e = jit ? maj(in_h[3:1]) : in_h[1];
      chk(fiber_tx_data[1], e);
      if (!cut[0]) chk(fiber_tx_data[0], e);
      chk(ring_rx_out, rx_h[active_channel]);
    end
  endtask

  // ==========================================================================
  // clock, random traffic and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // an idle peer sends zeros: random data can imitate the fault pattern
  // and keep a remote fault from clearing
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      seed <= 32'h19;
      {ring_tx_in, peer_data, in_h, rx_h} <= '0;
    end else begin
      seed       <= xs(seed);
      ring_tx_in <= traffic & seed[3];
      peer_data  <= traffic & seed[7];
      in_h       <= {in_h[2:0], ring_tx_in};
      rx_h       <= fiber_rx_data;
    end
  end
  initial begin
    cyc(30000);
    fail_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    test_done();
  end

  // ==========================================================================
  // scenarios
  initial begin
    {sys_rst, prot_peer, our_light} = 4'hF;
    {reg_wr, reg_rd, traffic} = 3'h0;
    {cut, reg_addr, reg_wdata} = '0;
    fail_count = 0;
    checks_done = 0;
    cyc(8);
    sys_rst <= 1'b0;
    rd(REG_CONFIG, 32'h13);
    chk(rate_16m_ind, 1'b1);
    wr(4'h8, 32'h1F);
    rd(4'h8, 32'h0);
    wr(REG_STATUS, 32'h7FF);
    cyc(1100);
    rd(REG_STATUS, 32'h001);
    chk({relay_energize, loopback_active, fault_indicator}, 3'h4);
    chk({ring_entry_role, ring_exit_role}, 2'h2);
    $display("test reset done");
    traffic <= 1'b1;
    wr(REG_CONFIG, 32'h11);
    cyc(6);
    path(1'b0);
    wr(REG_CONFIG, 32'hFFFFFFF3);
    rd(REG_CONFIG, 32'h13);
    cyc(6);
    path(1'b1);
    $display("test data path done");
    // a dark spell shorter than the debounce must not loop
    traffic <= 1'b0;
    cut <= 2'h1;
    cyc(500);
    cut <= 2'h0;
    cyc(1100);
    chk(loopback_active, 1'b0);
    cut <= 2'h1;
    cyc(995);
    #1 chk(loopback_active, 1'b0);
    cyc(10);
    #1 chk({loopback_active, fault_indicator}, 2'h3);
    rd(REG_STATUS, 32'h422);
    repeat (16) @(posedge ref_clk) #1 chk(ring_rx_out, 1'b0);
    cut <= 2'h0;
    cyc(1100);
    chk({loopback_active, fault_indicator}, 2'h0);
    $display("test local loss done");
    our_light <= 2'h2;
    cyc(1100);
    chk(loopback_active, 1'b1);
    flashes(8 * BLINK, t);
    chk(t, 8);
    rd(REG_STATUS, 32'h484);
    our_light <= 2'h3;
    cyc(1100);
    chk(loopback_active, 1'b0);
    $display("test remote fault done");
    prot_peer <= 1'b0;
    wr(REG_CONFIG, 32'h12);
    cut <= 2'h1;
    cyc(1100);
    chk({loopback_active, fault_indicator}, 2'h1);
    repeat (8) @(posedge ref_clk) #1 chk(fiber_tx_data[0], 1'b0);
    rd(REG_STATUS, 32'h028);
    cut <= 2'h0;
    cyc(1100);
    wr(REG_CONFIG, 32'h0E);
    cyc(4);
    chk({relay_energize, loopback_active}, 2'h0);
    chk({ring_entry_role, ring_exit_role}, {2{fault_indicator}});
    flashes(4 * BLINK, t);
    chk(t, 4);
    rd(REG_STATUS, 32'h010);
    $display("test protection off done");
    prot_peer <= 1'b1;
    wr(REG_CONFIG, 32'h0F);
    cyc(4);
    chk({ring_entry_role, ring_exit_role}, 2'h1);
    cut <= 2'h1;
    traffic <= 1'b1;
    cyc(1100);
    chk({active_channel, loopback_active}, 2'h2);
    path(1'b1);
    $display("test redundant done");
    test_done();
  end
endmodule
